// file: dmct_pkg.sv
// Operation
// R1: Low wrap interrupt enable blocks low overflow interrupts at 0, allows at 1.
// R2: Low match-clear at 1 clears the low counter on its compare match.
// R3: In 16-bit mode CPU accesses the upper byte first, then lower.
// R4: Upper-byte write goes to the latch; lower write commits both bytes together.
// R5: Counter upper read returns it directly and latches the lower byte.
// R6: Compare register byte reads return contents directly, bypassing the latch.
// R7: Upper clock select top bit 0 gives 16-bit mode; 1 gives two 8-bit timers.
// R8: Reset gives counter zero, compare all ones, control and status zero.
// R9: 16-bit match sets upper flag, toggles upper pin, may interrupt and clear.
// R10: 16-bit wrap sets upper wrap flag; interrupt needs wrap and interrupt enables.
// R11: 8-bit halves match independently: flag, interrupt, toggle, optional clear.
// R12: 8-bit half wrap sets its flag; interrupt needs both its enables.
// R13: Internal count clocks are system clock divided by 32, 16, 4 or 2.
// R14: Lower select top bit 0 counts external event edges of the chosen polarity.
// R15: External event pulses last at least two system clock cycles.
// R16: Toggle pins drive the output-level field and invert on each match.
// R17: Match signal is issued when the counter leaves the matching value.
// R18: Counter halts in low-power modes other than sleep; registers are retained.
// R19: Control write together with a match makes the pin take the written level.
// R20: Compare write with a match suppresses it; matches follow the count clock.
// R21: In 16-bit mode the low flags still follow the lower eight bits.
// R22: Counter half write coinciding with its overflow suppresses the overflow.
// R23: Flags are set by hardware; cleared by reading 1 then writing 0.
// R24: Output-level write drives the pin right after the write.
package dmct_pkg;
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_STAT = 3'h1;
  localparam logic [2:0] ADDR_CNT_HI = 3'h2;
  localparam logic [2:0] ADDR_CNT_LO = 3'h3;
  localparam logic [2:0] ADDR_CMP_HI = 3'h4;
  localparam logic [2:0] ADDR_CMP_LO = 3'h5;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'hFFFF;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam int CTL_OUT_HI = 7;
  localparam int CTL_SEL_HI_TOP = 6;
  localparam int CTL_OUT_LO = 3;
  localparam int CTL_SEL_LO_TOP = 2;
  localparam int ST_WRAP_HI = 7;
  localparam int ST_MATCH_HI = 6;
  localparam int ST_WIE_HI = 5;
  localparam int ST_CLR_HI = 4;
  localparam int ST_WRAP_LO = 3;
  localparam int ST_MATCH_LO = 2;
  localparam int ST_WIE_LO = 1;
  localparam int ST_CLR_LO = 0;
  localparam int PRESCALE_W = 5;
  localparam logic [1:0] SEL_DIV32 = 2'h0;
  localparam logic [1:0] SEL_DIV16 = 2'h1;
  localparam logic [1:0] SEL_DIV4 = 2'h2;
endpackage

// file: dmct_tick_sel.sv
`timescale 1ns/1ps
`default_nettype none
module dmct_tick_sel
(
  input wire logic [4:0] prescale,
  input wire logic [4:0] prescale_prev,
  input wire logic [1:0] sel,
  output logic tick
);
  logic [4:0] fall;
  // A divided clock ticks on each falling edge of its prescaler bit.
  assign fall = prescale_prev & ~prescale;
  always_comb
  begin
    case (sel)
      dmct_pkg::SEL_DIV32: tick = fall[4];
      dmct_pkg::SEL_DIV16: tick = fall[3];
      dmct_pkg::SEL_DIV4: tick = fall[1];
      default: tick = fall[0];
    endcase
  end
endmodule
`default_nettype wire

// file: dmct_half.sv
`timescale 1ns/1ps
`default_nettype none
module dmct_half
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic match_cond,
  input wire logic clear_on_match,
  input wire logic cmp_write,
  input wire logic cnt_write,
  input wire logic [7:0] cnt_wdata,
  output logic [7:0] count,
  output logic match_pulse,
  output logic wrap_pulse
);
  // Match fires as the counter leaves the matching value, on its own tick.
  assign match_pulse = tick && match_cond && !cmp_write; // R17 R20
  assign wrap_pulse = tick && count == dmct_pkg::BYTE_MAX && !cnt_write; // R22
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      count <= dmct_pkg::CNT_RESET[7:0];
    else if (cnt_write)
      count <= cnt_wdata;
    else if (match_pulse && clear_on_match)
      count <= 8'h00; // R2 R9 R11
    else if (tick)
      count <= count + 8'h01;
  end
endmodule
`default_nettype wire

// file: dmct_top.sv
`timescale 1ns/1ps
`default_nettype none
module dmct_top
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic run_enable,
  input wire logic event_input_pin,
  input wire logic event_edge_select,
  output logic toggle_pin_upper,
  output logic toggle_pin_lower,
  output logic irq_upper,
  output logic irq_lower
);
  // ==========================================================
  // Registers
  logic [7:0] timer_control;
  logic [7:0] status_bits;
  logic [15:0] compare_value;
  logic [7:0] byte_latch;
  logic [3:0] flag_seen;
  logic [4:0] prescale;
  logic [4:0] prescale_prev;
  logic event_prev;
  logic [7:0] cnt_hi;
  logic [7:0] cnt_lo;
  logic tick_hi_int;
  logic tick_lo_int;
  logic tick_lo;
  logic tick_hi;
  logic mode8;
  logic ev_edge;
  logic match_lo;
  logic match_hi;
  logic wrap_lo;
  logic wrap_hi;
  logic match_cond_hi;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_cnt_hi;
  logic wr_cnt_lo;
  logic wr_cmp_lo;
  logic [7:0] cnt_hi_wdata;
  logic [7:0] flag_mask;
  logic wr_cmp_hi;
  logic clr16_hi;
  localparam logic [7:0] REG_ZERO = dmct_pkg::REG_RESET;

  assign mode8 = timer_control[dmct_pkg::CTL_SEL_HI_TOP]; // R7
  assign wr_ctrl = wr_en && addr == dmct_pkg::ADDR_CTRL;
  assign wr_stat = wr_en && addr == dmct_pkg::ADDR_STAT;
  // In 16-bit mode the upper byte is staged and committed with the lower write.
  assign wr_cnt_hi = wr_en && (mode8 ? addr == dmct_pkg::ADDR_CNT_HI
    : addr == dmct_pkg::ADDR_CNT_LO); // R3 R4
  assign wr_cnt_lo = wr_en && addr == dmct_pkg::ADDR_CNT_LO;
  assign wr_cmp_lo = wr_en && addr == dmct_pkg::ADDR_CMP_LO;
  assign wr_cmp_hi = wr_en && addr == dmct_pkg::ADDR_CMP_HI;
  assign cnt_hi_wdata = mode8 ? wdata : byte_latch; // R4

  // ==========================================================
  // Count clocks
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      prescale <= '0;
      prescale_prev <= '0;
      event_prev <= 1'b0;
    end
    else
    begin
      prescale <= prescale + 5'h01;
      prescale_prev <= prescale;
      event_prev <= event_input_pin;
    end
  end

  // Edge detection assumes pulses held two cycles by the source.
  assign ev_edge = event_edge_select ? (event_input_pin && !event_prev)
    : (!event_input_pin && event_prev); // R14 R15

  dmct_tick_sel u_sel_lo
  (
    .prescale(prescale),
    .prescale_prev(prescale_prev),
    .sel(timer_control[1:0]),
    .tick(tick_lo_int)
  ); // R13

  dmct_tick_sel u_sel_hi
  (
    .prescale(prescale),
    .prescale_prev(prescale_prev),
    .sel(timer_control[5:4]),
    .tick(tick_hi_int)
  ); // R13

  // Halted in low-power modes other than sleep; registers are kept.
  assign tick_lo = run_enable && (timer_control[dmct_pkg::CTL_SEL_LO_TOP]
    ? tick_lo_int : ev_edge); // R18 R14
  // In 16-bit mode the upper half counts the carries out of the lower half.
  assign tick_hi = run_enable && (mode8 ? tick_hi_int
    : (tick_lo && cnt_lo == dmct_pkg::BYTE_MAX)); // R7

  // In 16-bit mode the upper half only matches together with the lower byte.
  assign match_cond_hi = mode8 ? cnt_hi == compare_value[15:8]
    : ({cnt_hi, cnt_lo} == compare_value); // R9

  // ==========================================================
  // Counter halves
  logic clr_hi_now;
  assign clr_hi_now = status_bits[dmct_pkg::ST_CLR_HI];

  dmct_half u_lo
  (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick_lo),
    .match_cond(mode8 ? cnt_lo == compare_value[7:0] : match_cond_hi),
    .clear_on_match(mode8 ? status_bits[dmct_pkg::ST_CLR_LO] : clr_hi_now),
    .cmp_write(wr_cmp_lo),
    .cnt_write(wr_cnt_lo),
    .cnt_wdata(wdata),
    .count(cnt_lo),
    .match_pulse(),
    .wrap_pulse(wrap_lo)
  );

  // Lower byte match in either mode, for the low flag; it drives the low pin only in 8-bit mode.
  assign match_lo = tick_lo && cnt_lo == compare_value[7:0] && !wr_cmp_lo; // R21 R11

  // The 16-bit match follows the lower count clock, not the upper carry.
  assign match_hi = (mode8 ? tick_hi : tick_lo) && match_cond_hi
    && !(mode8 ? wr_cmp_hi : wr_cmp_lo); // R9 R11 R17 R20
  // A 16-bit clear must also zero the upper half, which ticks then only if the compare low byte is FF.
  assign clr16_hi = !mode8 && match_hi && clr_hi_now; // R9

  dmct_half u_hi
  (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick_hi),
    .match_cond(match_cond_hi),
    .clear_on_match(clr_hi_now),
    .cmp_write(mode8 ? wr_cmp_hi : wr_cmp_lo),
    .cnt_write(wr_cnt_hi || clr16_hi),
    .cnt_wdata(wr_cnt_hi ? cnt_hi_wdata : dmct_pkg::CNT_RESET[15:8]),
    .count(cnt_hi),
    .match_pulse(),
    .wrap_pulse()
  );

  // Upper wrap: in 16-bit mode the whole count wraps.
  assign wrap_hi = tick_hi && cnt_hi == dmct_pkg::BYTE_MAX && !wr_cnt_hi
    && (mode8 || cnt_lo == dmct_pkg::BYTE_MAX); // R10 R12 R22

  // ==========================================================
  // Control, compare and status
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      timer_control <= dmct_pkg::REG_RESET; // R8
    else if (wr_ctrl)
      timer_control <= wdata;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      compare_value <= dmct_pkg::CMP_RESET; // R8
    else if (wr_en && addr == dmct_pkg::ADDR_CMP_HI && mode8)
      compare_value[15:8] <= wdata;
    else if (wr_cmp_lo)
    begin
      compare_value[7:0] <= wdata;
      if (!mode8)
        compare_value[15:8] <= byte_latch; // R4
    end
  end

  // Byte latch: upper writes stage, upper counter reads capture the lower byte.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      byte_latch <= REG_ZERO;
    else if (wr_en && (addr == dmct_pkg::ADDR_CNT_HI || addr == dmct_pkg::ADDR_CMP_HI))
      byte_latch <= wdata; // R4
    else if (rd_en && addr == dmct_pkg::ADDR_CNT_HI)
      byte_latch <= cnt_lo; // R5
  end

  // Flag bits that software may clear: those read as 1 since the last clear.
  assign flag_mask = {flag_seen[3], flag_seen[2], 2'b00, flag_seen[1], flag_seen[0], 2'b00};

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      flag_seen <= '0;
    else if (rd_en && addr == dmct_pkg::ADDR_STAT)
      flag_seen <= {status_bits[7], status_bits[6], status_bits[3], status_bits[2]}; // R23
    else if (wr_stat)
      flag_seen <= '0;
  end

  // A hardware set in the same cycle as a software clear wins.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      status_bits <= dmct_pkg::REG_RESET; // R8
    else
    begin
      if (wr_stat)
      begin
        status_bits[5:4] <= wdata[5:4];
        status_bits[1:0] <= wdata[1:0];
        status_bits[7:6] <= status_bits[7:6] & (wdata[7:6] | ~flag_mask[7:6]); // R23
        status_bits[3:2] <= status_bits[3:2] & (wdata[3:2] | ~flag_mask[3:2]); // R23
      end
      if (wrap_hi)
        status_bits[dmct_pkg::ST_WRAP_HI] <= 1'b1; // R10 R12
      if (match_hi)
        status_bits[dmct_pkg::ST_MATCH_HI] <= 1'b1; // R9 R11
      if (wrap_lo)
        status_bits[dmct_pkg::ST_WRAP_LO] <= 1'b1; // R12 R21
      if (match_lo)
        status_bits[dmct_pkg::ST_MATCH_LO] <= 1'b1; // R11 R21
    end
  end

  // ==========================================================
  // Toggle pins and interrupt requests
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      toggle_pin_upper <= 1'b0;
      toggle_pin_lower <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        toggle_pin_upper <= wdata[dmct_pkg::CTL_OUT_HI]; // R19 R24
        toggle_pin_lower <= wdata[dmct_pkg::CTL_OUT_LO]; // R19 R24
      end
      else
      begin
        if (match_hi)
          toggle_pin_upper <= ~toggle_pin_upper; // R16 R9
        if (match_lo && mode8)
          toggle_pin_lower <= ~toggle_pin_lower; // R16 R11
      end
    end
  end

  // One-cycle requests; the system interrupt enable gates them outside.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      irq_upper <= 1'b0;
      irq_lower <= 1'b0;
    end
    else
    begin
      irq_upper <= match_hi || (wrap_hi && status_bits[dmct_pkg::ST_WIE_HI]); // R10
      irq_lower <= (match_lo && mode8)
        || (wrap_lo && status_bits[dmct_pkg::ST_WIE_LO]); // R1 R12
    end
  end

  // ==========================================================
  // Read data, registered
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rdata <= REG_ZERO;
    else if (rd_en)
    begin
      case (addr)
        dmct_pkg::ADDR_STAT: rdata <= status_bits;
        dmct_pkg::ADDR_CNT_HI: rdata <= cnt_hi; // R5
        dmct_pkg::ADDR_CNT_LO: rdata <= mode8 ? cnt_lo : byte_latch; // R5
        dmct_pkg::ADDR_CMP_HI: rdata <= compare_value[15:8]; // R6
        dmct_pkg::ADDR_CMP_LO: rdata <= compare_value[7:0]; // R6
        default: rdata <= REG_ZERO;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: dmct_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dmct_top_asserts
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic run_enable,
  input wire logic event_input_pin,
  input wire logic event_edge_select,
  input wire logic toggle_pin_upper,
  input wire logic toggle_pin_lower,
  input wire logic irq_upper,
  input wire logic irq_lower
);
  // ==========================================================
  // Port checks
  default clocking dcb @(posedge clock);
  endclocking
  // The reset checks carry no disable, so they can see the reset itself.
  a_reset_pins: assert property (!rst_n |=> !toggle_pin_upper && !toggle_pin_lower)
    else $error("toggle pins not low after reset");
  a_reset_irq: assert property (!rst_n |=> !irq_upper && !irq_lower)
    else $error("interrupt pulse after reset");
  a_rdata_holds: assert property (disable iff (!rst_n) !rd_en |=> $stable(rdata))
    else $error("read data moved without a read");
  a_ctrl_reads_zero: assert property (disable iff (!rst_n)
    rd_en && addr == dmct_pkg::ADDR_CTRL |=> rdata == 8'h00)
    else $error("control register read not zero");
  a_level_upper: assert property (disable iff (!rst_n) wr_en && addr == dmct_pkg::ADDR_CTRL
    |=> toggle_pin_upper == $past(wdata[7]))
    else $error("upper pin missed written level");
  a_level_lower: assert property (disable iff (!rst_n) wr_en && addr == dmct_pkg::ADDR_CTRL
    && wdata[6] |=> toggle_pin_lower == $past(wdata[3]))
    else $error("lower pin missed written level");
  a_irq_single: assert property (disable iff (!rst_n) irq_upper |=> !irq_upper)
    else $error("upper interrupt longer than one cycle");
  a_halt_quiet: assert property (disable iff (!rst_n) (!run_enable && !wr_en)[*4]
    |=> !irq_upper && !irq_lower && $stable(toggle_pin_upper))
    else $error("activity while counting halted");
endmodule
bind dmct_top dmct_top_asserts u_chk (.clock(clock), .rst_n(rst_n), .addr(addr),
  .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .run_enable(run_enable),
  .event_input_pin(event_input_pin), .event_edge_select(event_edge_select),
  .toggle_pin_upper(toggle_pin_upper), .toggle_pin_lower(toggle_pin_lower),
  .irq_upper(irq_upper), .irq_lower(irq_lower));
`default_nettype wire

// file: dmct_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmct_cpu_model
(
  input wire logic clock,
  output logic [2:0] addr,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  // ==========================================================
  // Byte bus cycles
  initial
  begin
    addr = 3'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = 8'h00;
  end
  // One strobe cycle per access; the caller orders the two bytes of a pair.
  task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    @(posedge clock);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    // Stale data is inverted so nothing can lean on a held bus value.
    wdata <= ~d;
    #1;
    q = rdata;
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic run_enable = 1'b0;
  logic event_input_pin = 1'b0;
  logic event_edge_select = 1'b1;
  wire [2:0] addr;
  wire wr_en;
  wire rd_en;
  wire [7:0] wdata;
  logic [7:0] rdata;
  logic toggle_pin_upper;
  logic toggle_pin_lower;
  logic irq_upper;
  logic irq_lower;
  logic pl = 1'b0;
  logic pu = 1'b0;
  logic [7:0] q;
  logic [15:0] v;
  int fail_count = 0;
  int n_tests = 0;
  int seed = 1;
  int cyc = 0;
  int tl = 0;
  int tu = 0;
  int gl = 0;
  int gu = 0;
  int nil = 0;
  int niu = 0;
  int div[4] = '{32, 16, 4, 2};
  dmct_top uut (.clock(clock), .rst_n(rst_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wdata(wdata), .rdata(rdata), .run_enable(run_enable), .event_input_pin(event_input_pin),
    .event_edge_select(event_edge_select), .toggle_pin_upper(toggle_pin_upper),
    .toggle_pin_lower(toggle_pin_lower), .irq_upper(irq_upper), .irq_lower(irq_lower));
  dmct_cpu_model cpu (.clock(clock), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wdata(wdata), .rdata(rdata));
  initial
  begin
    forever #5 clock = ~clock;
  end
  // ==========================================================
  // Pin monitor: the last gap between toggles is the steady match period.
  always @(posedge clock)
  begin
    cyc++;
    nil += irq_lower;
    niu += irq_upper;
    if (toggle_pin_lower !== pl)
    begin
      gl = cyc - tl;
      tl = cyc;
      pl = toggle_pin_lower;
    end
    if (toggle_pin_upper !== pu)
    begin
      gu = cyc - tu;
      tu = cyc;
      pu = toggle_pin_upper;
    end
  end
  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cpu.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    cpu.xfer(1'b0, a, 8'h00, q);
    chk("register byte", 16'(e), 16'(q));
  endtask
  task automatic wr16(input logic [2:0] a, input logic [15:0] d);
    wr(a, d[15:8]);
    wr(3'(a + 1), d[7:0]);
  endtask
  task automatic rd16(input logic [2:0] a, input logic [15:0] e);
    rd(a, e[15:8]);
    rd(3'(a + 1), e[7:0]);
  endtask
  task automatic run(input int n);
    run_enable <= 1'b1;
    repeat (n) @(posedge clock);
    run_enable <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic pulses(input int n);
    repeat (n)
    begin
      event_input_pin <= 1'b1;
      repeat (3) @(posedge clock);
      event_input_pin <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd16(3'h2, dmct_pkg::CNT_RESET);
    rd16(3'h4, dmct_pkg::CMP_RESET);
    rd(3'h1, dmct_pkg::REG_RESET);
    rd(3'h0, 8'h00);
    repeat (4)
    begin
      v = 16'($random(seed));
      wr16(3'h2, v);
      rd16(3'h2, v);
      wr16(3'h4, ~v);
      rd16(3'h4, ~v);
    end
    wr16(3'h2, 16'h1234);
    rd(3'h2, 8'h12);
    run_enable <= 1'b1;
    pulses(1);
    run_enable <= 1'b0;
    rd(3'h3, 8'h34);
    rd16(3'h2, 16'h1235);
    for (int s = 0; s < 4; s++)
    begin
      wr(3'h0, 8'h44 | 8'(s * 17));
      wr(3'h1, 8'h11);
      wr(3'h4, 8'h03);
      wr(3'h5, 8'h03);
      wr(3'h2, 8'h00);
      wr(3'h3, 8'h00);
      run(16 * div[s]);
      chk("lower toggle gap", 16'(4 * div[s]), 16'(gl));
      chk("upper toggle gap", 16'(4 * div[s]), 16'(gu));
    end
    rd(3'h1, 8'h55);
    wr(3'h1, 8'h11);
    rd(3'h1, 8'h11);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'h33);
    wr(3'h0, 8'h77);
    for (int e = 1; e >= 0; e--)
    begin
      wr(3'h1, 8'(e * 34));
      wr(3'h4, 8'h80);
      wr(3'h5, 8'h80);
      wr(3'h2, 8'hFE);
      wr(3'h3, 8'hFE);
      niu = 0;
      nil = 0;
      run(20);
      rd(3'h1, 8'h88 | 8'(e * 34));
      chk("wrap interrupts", 16'(e * 2), 16'(niu + nil));
    end
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h07);
    wr16(3'h4, 16'h8080);
    wr16(3'h2, 16'hFFFE);
    run(20);
    rd(3'h1, 8'h88);
    wr(3'h1, 8'h10);
    wr16(3'h4, 16'h0101);
    wr16(3'h2, 16'h0000);
    niu = 0;
    run(1600);
    chk("16-bit toggle gap", 16'h0204, 16'(gu));
    chk("16-bit match interrupts", 16'h0003, 16'(niu));
    rd(3'h1, 8'h5C);
    wr(3'h0, 8'h40);
    run_enable <= 1'b1;
    for (int es = 0; es < 2; es++)
    begin
      event_edge_select <= 1'(es);
      wr(3'h3, 8'h00);
      pulses(5);
      rd(3'h3, 8'h05);
    end
    run_enable <= 1'b0;
    repeat (6) @(posedge clock);
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
